/* File: pkg/arc_regs.svh */
// Register offsets, field positions, reset values and timing constants of the alarm block.
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH
`define ARC_CLK_HZ 250000000
`define ARC_HOLD_S 10
`define ARC_DATE_MS 2000
`define ARC_OFF_CTRL 8'h00
`define ARC_OFF_HI 8'h04
`define ARC_OFF_LO 8'h08
`define ARC_OFF_DB 8'h0C
`define ARC_OFF_STAT 8'h10
`define ARC_OFF_CMD 8'h14
`define ARC_OFF_DATE 8'h18
`define ARC_C_AEN 0
`define ARC_C_LATCH 1
`define ARC_C_ACUR 2
`define ARC_C_RANGE 5:3
`define ARC_C_R1 7:6
`define ARC_C_R2 9:8
`define ARC_C_LOCK 10
`define ARC_C_BRIGHT 14:11
`define ARC_S_AHI 0
`define ARC_S_ALO 1
`define ARC_S_RL1 2
`define ARC_S_RL2 3
`define ARC_S_CURVE 4
`define ARC_S_LOCK 5
`define ARC_S_AOUT 31:16
`define ARC_K_RESTORE 0
`define ARC_K_CLEAR 1
`define ARC_SP_MAX 14'd9999
`define ARC_DB_MAX 14'd999
`define ARC_RANGE_MAX 14'd5
`define ARC_RANGE_DEF 3'd5
`define ARC_BRIGHT_DEF 4'h8
`define ARC_RMODE_MAX 14'd2
`define ARC_FS0 14'd200
`define ARC_FS1 14'd1000
`define ARC_FS2 14'd2000
`define ARC_FS3 14'd3250
`define ARC_FS4 14'd4750
`define ARC_FS5 14'd10000
`define ARC_CODE_MAX 16'hFFFF
`define ARC_FW_DATE 24'h010100
`endif

/* File: pkg/arc_pkg.sv */
// Types shared by the alarm, relay and analog output block.
`default_nettype none
package arc_pkg;
  typedef enum logic [10:0] {
    ARC_NORM = 11'h001, ARC_PICK = 11'h002, ARC_A_EN = 11'h004, ARC_A_HI = 11'h008,
    ARC_A_LO = 11'h010, ARC_A_DB = 11'h020, ARC_A_LT = 11'h040, ARC_R1 = 11'h080,
    ARC_R2 = 11'h100, ARC_O_MD = 11'h200, ARC_O_RG = 11'h400
  } arc_menu_t;
  typedef enum logic [1:0] {
    ARC_FORCED_OFF = 2'h0, ARC_FORCED_ON = 2'h1, ARC_FOLLOW = 2'h2
  } arc_rmode_t;
  typedef struct packed {
    logic up;
    logic dn;
    logic enter;
    logic sel;
  } arc_keys_t;
  typedef struct packed {
    logic [15:0] temp;
    logic curve_ok;
    logic off_hi;
    logic off_lo;
    logic [15:0] sensor_val;
  } arc_meas_t;
  typedef struct packed {
    arc_menu_t menu;
    logic [1:0] pick;
    logic [13:0] edit;
    logic alarm_hi;
    logic alarm_lo;
    logic locked_msg;
    logic unlocked_msg;
    logic all_lit;
    logic date_show;
    logic [23:0] date;
  } arc_disp_t;
endpackage
`default_nettype wire

/* File: logic/arc_top.sv */
// Alarm, relay, analog output and keypad control with an AHB-Lite register slave.
`timescale 1ns/1ns
`default_nettype none
`include "arc_regs.svh"
module arc_top #(
  parameter logic [31:0] HOLD_CYC = 32'(64'd`ARC_HOLD_S * 64'd`ARC_CLK_HZ),
  parameter logic [31:0] DATE_CYC = 32'(64'd`ARC_DATE_MS * 64'd`ARC_CLK_HZ / 64'd1000),
  parameter logic [23:0] FW_DATE = `ARC_FW_DATE
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire arc_pkg::arc_keys_t keys,
  input wire arc_pkg::arc_meas_t meas,
  output logic relay1,
  output logic relay2,
  output logic [15:0] aout_code,
  output logic aout_current,
  output logic [3:0] brightness,
  output arc_pkg::arc_disp_t disp
);
  import arc_pkg::*;

  typedef struct packed {
    arc_menu_t menu;
    logic [1:0] pick;
    logic [13:0] edit;
    logic aen;
    logic latch;
    logic acur;
    logic [2:0] range;
    logic [1:0] r1m;
    logic [1:0] r2m;
    logic locked;
    logic [3:0] bright;
    logic [13:0] hi;
    logic [13:0] lo;
    logic [13:0] db;
    logic alm_hi;
    logic alm_lo;
    logic rl1;
    logic rl2;
    logic [15:0] aout;
    arc_keys_t kq;
    logic [31:0] ent_cnt;
    logic [31:0] arr_cnt;
    logic [31:0] sel_cnt;
    logic ent_done;
    logic arr_done;
    logic lock_msg;
    logic unlock_msg;
    logic all_lit;
    logic date_show;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic rdy;
  } arc_st_t;

  localparam arc_st_t ST_RST = '{menu: ARC_NORM, range: `ARC_RANGE_DEF,
                                 bright: `ARC_BRIGHT_DEF, default: '0};

  logic [13:0] fs_tab [6];
  assign fs_tab[0] = `ARC_FS0;
  assign fs_tab[1] = `ARC_FS1;
  assign fs_tab[2] = `ARC_FS2;
  assign fs_tab[3] = `ARC_FS3;
  assign fs_tab[4] = `ARC_FS4;
  assign fs_tab[5] = `ARC_FS5;

  logic rst_meta_r;
  logic rst_sync_r;
  arc_st_t st_r;
  arc_st_t st_nxt;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Limit for the value being edited in each setting step.
  function automatic logic [13:0] edit_max(input arc_menu_t m);
    case (m)
      ARC_A_HI, ARC_A_LO: edit_max = `ARC_SP_MAX;
      ARC_A_DB: edit_max = `ARC_DB_MAX;
      ARC_R1, ARC_R2: edit_max = `ARC_RMODE_MAX;
      ARC_O_RG: edit_max = `ARC_RANGE_MAX;
      default: edit_max = 14'd1;
    endcase
  endfunction

  // Current stored value shown when a setting step is entered.
  function automatic logic [13:0] edit_load(input arc_menu_t m, input arc_st_t s);
    case (m)
      ARC_A_EN: edit_load = {13'd0, s.aen};
      ARC_A_HI: edit_load = s.hi;
      ARC_A_LO: edit_load = s.lo;
      ARC_A_DB: edit_load = s.db;
      ARC_A_LT: edit_load = {13'd0, s.latch};
      ARC_R1: edit_load = {12'd0, s.r1m};
      ARC_R2: edit_load = {12'd0, s.r2m};
      ARC_O_MD: edit_load = {13'd0, s.acur};
      ARC_O_RG: edit_load = {11'd0, s.range};
      default: edit_load = 14'd0;
    endcase
  endfunction

  function automatic logic [13:0] clamp(input logic [31:0] v, input logic [13:0] mx);
    clamp = (v > {18'd0, mx}) ? mx : v[13:0];
  endfunction

  function automatic logic [1:0] rclamp(input logic [1:0] v);
    rclamp = (v == 2'h3) ? ARC_FOLLOW : v;
  endfunction

  function automatic arc_st_t restore(input arc_st_t s);
    arc_st_t t;
    t = s;
    t.aen = 1'b0;
    t.hi = '0;
    t.lo = '0;
    t.db = '0;
    t.latch = 1'b0;
    t.acur = 1'b0;
    t.range = `ARC_RANGE_DEF;
    t.r1m = ARC_FORCED_OFF;
    t.r2m = ARC_FORCED_OFF;
    t.locked = 1'b0;
    t.bright = `ARC_BRIGHT_DEF;
    restore = t;
  endfunction

  logic up_p;
  logic dn_p;
  logic ent_p;
  logic sel_p;
  logic sel_rel;
  logic ent_rel;
  logic arr_rel;
  logic clr_req;
  logic hi_set;
  logic hi_clr;
  logic lo_set;
  logic lo_clr;
  logic [13:0] fs;
  logic [15:0] src;
  logic [45:0] prod;
  logic [31:0] kr;
  logic [7:0] ra;
  logic [31:0] rd;

  always_comb begin
    st_nxt = st_r;
    st_nxt.kq = keys;
    up_p = keys.up & ~st_r.kq.up;
    dn_p = keys.dn & ~st_r.kq.dn;
    ent_p = keys.enter & ~st_r.kq.enter;
    sel_p = keys.sel & ~st_r.kq.sel;
    sel_rel = ~keys.sel & st_r.kq.sel;
    ent_rel = ~keys.enter;
    arr_rel = ~(keys.up & keys.dn);
    clr_req = sel_p;

    // Long-hold counters saturate; ent_done and arr_done make each hold act once.
    st_nxt.ent_cnt = (ent_rel || st_r.ent_cnt == HOLD_CYC) ? (ent_rel ? '0 : st_r.ent_cnt)
                     : st_r.ent_cnt + 32'd1;
    st_nxt.arr_cnt = (arr_rel || st_r.arr_cnt == HOLD_CYC) ? (arr_rel ? '0 : st_r.arr_cnt)
                     : st_r.arr_cnt + 32'd1;
    st_nxt.sel_cnt = (!keys.sel || st_r.sel_cnt == DATE_CYC) ? (!keys.sel ? '0 : st_r.sel_cnt)
                     : st_r.sel_cnt + 32'd1;

    if (ent_rel) begin
      st_nxt.ent_done = 1'b0;
      st_nxt.lock_msg = 1'b0;
      st_nxt.unlock_msg = 1'b0;
    end else if (st_r.ent_cnt == HOLD_CYC && !st_r.ent_done) begin
      st_nxt.ent_done = 1'b1;
      st_nxt.locked = ~st_r.locked;
      st_nxt.lock_msg = ~st_r.locked;
      st_nxt.unlock_msg = st_r.locked;
      st_nxt.menu = ARC_NORM;
    end

    if (arr_rel) begin
      st_nxt.arr_done = 1'b0;
      st_nxt.all_lit = 1'b0;
    end else if (st_r.arr_cnt == HOLD_CYC && !st_r.arr_done && !st_r.locked) begin
      st_nxt = restore(st_nxt);
      st_nxt.arr_done = 1'b1;
      st_nxt.all_lit = 1'b1;
      st_nxt.menu = ARC_NORM;
    end

    if (sel_rel && st_r.date_show) begin
      st_nxt.date_show = 1'b0;
      st_nxt.menu = ARC_NORM;
    end else if (st_r.sel_cnt == DATE_CYC && keys.sel && !st_r.locked) begin
      st_nxt.date_show = 1'b1;
    end

    // Keypad menu; all of it is skipped while locked.
    if (!st_r.locked && !st_r.date_show) begin
      if (st_r.menu == ARC_NORM) begin
        if (sel_p) begin
          st_nxt.menu = ARC_PICK;
          st_nxt.pick = 2'd0;
        end
      end else if (sel_p) begin
        st_nxt.menu = ARC_NORM;
      end else if (st_r.menu == ARC_PICK) begin
        if (up_p) begin
          st_nxt.pick = (st_r.pick == 2'd2) ? 2'd0 : st_r.pick + 2'd1;
        end else if (dn_p) begin
          st_nxt.pick = (st_r.pick == 2'd0) ? 2'd2 : st_r.pick - 2'd1;
        end else if (ent_p) begin
          case (st_r.pick)
            2'd0: st_nxt.menu = ARC_A_EN;
            2'd1: st_nxt.menu = ARC_R1;
            default: st_nxt.menu = ARC_O_MD;
          endcase
          st_nxt.edit = edit_load(st_nxt.menu, st_r);
        end
      end else if (up_p) begin
        st_nxt.edit = clamp({18'd0, st_r.edit} + 32'd1, edit_max(st_r.menu));
      end else if (dn_p) begin
        st_nxt.edit = (st_r.edit == 14'd0) ? 14'd0 : st_r.edit - 14'd1;
      end else if (ent_p) begin
        case (st_r.menu)
          ARC_A_EN: begin
            st_nxt.aen = st_r.edit[0];
            st_nxt.menu = st_r.edit[0] ? ARC_A_HI : ARC_NORM;
          end
          ARC_A_HI: begin
            st_nxt.hi = st_r.edit;
            st_nxt.menu = ARC_A_LO;
          end
          ARC_A_LO: begin
            st_nxt.lo = st_r.edit;
            st_nxt.menu = ARC_A_DB;
          end
          ARC_A_DB: begin
            st_nxt.db = st_r.edit;
            st_nxt.menu = ARC_A_LT;
          end
          ARC_A_LT: begin
            st_nxt.latch = st_r.edit[0];
            st_nxt.menu = ARC_NORM;
          end
          ARC_R1: begin
            st_nxt.r1m = st_r.edit[1:0];
            st_nxt.menu = ARC_R2;
          end
          ARC_R2: begin
            st_nxt.r2m = st_r.edit[1:0];
            st_nxt.menu = ARC_NORM;
          end
          ARC_O_MD: begin
            st_nxt.acur = st_r.edit[0];
            st_nxt.menu = ARC_O_RG;
          end
          ARC_O_RG: begin
            st_nxt.range = st_r.edit[2:0];
            st_nxt.menu = ARC_NORM;
          end
          default: st_nxt.menu = ARC_NORM;
        endcase
        if (st_nxt.menu != ARC_NORM) begin
          st_nxt.edit = edit_load(st_nxt.menu, st_nxt);
        end
      end
    end

    // AHB-Lite data phase of a write captured in the previous address phase.
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        `ARC_OFF_CTRL: begin
          st_nxt.aen = hwdata[`ARC_C_AEN];
          st_nxt.latch = hwdata[`ARC_C_LATCH];
          st_nxt.acur = hwdata[`ARC_C_ACUR];
          st_nxt.range = 3'(clamp({29'd0, hwdata[`ARC_C_RANGE]},
                                  `ARC_RANGE_MAX));
          st_nxt.r1m = rclamp(hwdata[`ARC_C_R1]);
          st_nxt.r2m = rclamp(hwdata[`ARC_C_R2]);
          st_nxt.locked = hwdata[`ARC_C_LOCK];
          st_nxt.bright = hwdata[`ARC_C_BRIGHT];
        end
        `ARC_OFF_HI: st_nxt.hi = clamp(hwdata, `ARC_SP_MAX);
        `ARC_OFF_LO: st_nxt.lo = clamp(hwdata, `ARC_SP_MAX);
        `ARC_OFF_DB: st_nxt.db = clamp(hwdata, `ARC_DB_MAX);
        `ARC_OFF_CMD: begin
          if (hwdata[`ARC_K_RESTORE]) begin
            st_nxt = restore(st_nxt);
          end
          clr_req = sel_p | hwdata[`ARC_K_CLEAR];
        end
        default: ;
      endcase
    end

    // Alarm evaluation with deadband, latching and the curve condition.
    hi_set = meas.off_hi || ({2'd0, meas.temp} > {4'd0, st_r.hi});
    hi_clr = !meas.off_hi && ({2'd0, meas.temp} + {4'd0, st_r.db} <= {4'd0, st_r.hi});
    lo_set = meas.off_lo || ({2'd0, meas.temp} < {4'd0, st_r.lo});
    lo_clr = !meas.off_lo && ({2'd0, meas.temp} >= {4'd0, st_r.lo} + {4'd0, st_r.db});
    if (!meas.curve_ok || !st_r.aen) begin
      st_nxt.alm_hi = 1'b0;
      st_nxt.alm_lo = 1'b0;
    end else begin
      if (hi_set) begin
        st_nxt.alm_hi = 1'b1;
      end else if (st_r.latch ? clr_req : hi_clr) begin
        st_nxt.alm_hi = 1'b0;
      end
      if (lo_set) begin
        st_nxt.alm_lo = 1'b1;
      end else if (st_r.latch ? clr_req : lo_clr) begin
        st_nxt.alm_lo = 1'b0;
      end
    end

    // Relay one pairs with the low alarm, relay two with the high alarm.
    st_nxt.rl1 = (st_r.r1m == ARC_FORCED_ON) ||
                 (st_r.r1m == ARC_FOLLOW && st_r.alm_lo);
    st_nxt.rl2 = (st_r.r2m == ARC_FORCED_ON) ||
                 (st_r.r2m == ARC_FOLLOW && st_r.alm_hi);

    // Output code = value * 65535 / full scale, via a fixed-point reciprocal.
    fs = meas.curve_ok ? fs_tab[st_r.range] : `ARC_FS5;
    src = meas.curve_ok ? meas.temp : meas.sensor_val;
    kr = 32'((64'({`ARC_CODE_MAX, 16'h0000}) + 64'(fs) - 64'd1) / 64'(fs));
    prod = 46'(src) * 46'(kr);
    st_nxt.aout = (prod[45:16] > 30'(`ARC_CODE_MAX)) ? `ARC_CODE_MAX
                  : prod[31:16];

    // AHB-Lite address phase: zero wait states, read data registered here.
    ra = haddr[7:0];
    case (ra)
      `ARC_OFF_CTRL: begin
        rd = '0;
        rd[`ARC_C_AEN] = st_r.aen;
        rd[`ARC_C_LATCH] = st_r.latch;
        rd[`ARC_C_ACUR] = st_r.acur;
        rd[`ARC_C_RANGE] = st_r.range;
        rd[`ARC_C_R1] = st_r.r1m;
        rd[`ARC_C_R2] = st_r.r2m;
        rd[`ARC_C_LOCK] = st_r.locked;
        rd[`ARC_C_BRIGHT] = st_r.bright;
      end
      `ARC_OFF_HI: rd = {18'd0, st_r.hi};
      `ARC_OFF_LO: rd = {18'd0, st_r.lo};
      `ARC_OFF_DB: rd = {18'd0, st_r.db};
      `ARC_OFF_STAT: begin
        rd = '0;
        rd[`ARC_S_AHI] = st_r.alm_hi;
        rd[`ARC_S_ALO] = st_r.alm_lo;
        rd[`ARC_S_RL1] = st_r.rl1;
        rd[`ARC_S_RL2] = st_r.rl2;
        rd[`ARC_S_CURVE] = meas.curve_ok;
        rd[`ARC_S_LOCK] = st_r.locked;
        rd[`ARC_S_AOUT] = st_r.aout;
      end
      `ARC_OFF_DATE: rd = {8'd0, FW_DATE};
      default: rd = '0;
    endcase
    st_nxt.rdy = 1'b1;
    st_nxt.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      st_nxt.wr_pend = hwrite;
      st_nxt.wr_addr = ra;
      st_nxt.rdata = hwrite ? '0 : rd;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = st_r.rdy;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign relay1 = st_r.rl1;
  assign relay2 = st_r.rl2;
  assign aout_code = st_r.aout;
  assign aout_current = st_r.acur;
  assign brightness = st_r.bright;
  assign disp.menu = st_r.menu;
  assign disp.pick = st_r.pick;
  assign disp.edit = st_r.edit;
  assign disp.alarm_hi = st_r.alm_hi;
  assign disp.alarm_lo = st_r.alm_lo;
  assign disp.locked_msg = st_r.lock_msg;
  assign disp.unlocked_msg = st_r.unlock_msg;
  assign disp.all_lit = st_r.all_lit;
  assign disp.date_show = st_r.date_show;
  assign disp.date = FW_DATE;
endmodule // arc_top
`default_nettype wire

/* File: verif/arc_top_props.sv */
// Port checks for the alarm block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module arc_top_props #(
  parameter logic [31:0] HOLD_CYC = 32'd50,
  parameter logic [23:0] FW_DATE = 24'h010100
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire arc_pkg::arc_keys_t keys,
  input wire arc_pkg::arc_meas_t meas,
  input wire logic [15:0] aout_code,
  input wire arc_pkg::arc_disp_t disp
);
  import arc_pkg::*;
  logic [31:0] held_r, held_nxt;
  // Counts consecutive edges with the enter key down.
  always_comb held_nxt = keys.enter ? held_r + 32'h1 : 32'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) held_r <= 32'h0;
    else held_r <= held_nxt;
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_no_curve_alarm: assert property (
    !$past(meas.curve_ok) |-> !disp.alarm_hi && !disp.alarm_lo) else $error("alarm without curve");
  a_hi_needs_curve: assert property (
    $rose(disp.alarm_hi) |-> $past(meas.curve_ok)) else $error("high alarm without curve");
  a_lit_needs_arrows: assert property (
    disp.all_lit |-> ($past(keys.up) && $past(keys.dn)) ||
    ($past(keys.up, 2) && $past(keys.dn, 2)))
    else $error("digits lit without arrows");
  a_date_needs_sel: assert property (
    disp.date_show |-> $past(keys.sel) || $past(keys.sel, 2)) else $error("date without select");
  a_date_value: assert property (disp.date == FW_DATE) else $error("wrong date");
  a_msg_needs_enter: assert property (
    disp.locked_msg || disp.unlocked_msg |-> $past(keys.enter) || $past(keys.enter, 2))
    else $error("lock message without enter");
  a_msg_exclusive: assert property (
    !(disp.locked_msg && disp.unlocked_msg)) else $error("both lock messages");
  a_lock_hold_time: assert property (
    $rose(disp.locked_msg || disp.unlocked_msg) |-> held_r + 32'd2 >= HOLD_CYC)
    else $error("lock toggled too early");
  a_raw_zero: assert property (
    !$past(meas.curve_ok) && $past(meas.sensor_val) == 16'h0 |-> aout_code == 16'h0)
    else $error("raw zero not zero code");
  a_raw_full: assert property (
    $past(hreadyout) && !$past(meas.curve_ok) && $past(meas.sensor_val) >= 16'd10000
    |-> aout_code == 16'hFFFF)
    else $error("raw full not full code");
endmodule // arc_top_props
bind arc_top arc_top_props #(.HOLD_CYC(HOLD_CYC), .FW_DATE(FW_DATE)) u_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .hreadyout(hreadyout), .keys(keys), .meas(meas), .aout_code(aout_code),
  .disp(disp));
`default_nettype wire

/* File: verif/arc_panel_model.sv */
// Keypad, sensor front end and output converter that face the alarm block.
`timescale 1ns/1ns
`default_nettype none
module arc_panel_model (
  input wire logic ref_clk,
  input wire logic relay1,
  input wire logic relay2,
  input wire logic [15:0] aout_code,
  input wire logic aout_current,
  output arc_pkg::arc_keys_t keys,
  output arc_pkg::arc_meas_t meas
);
  import arc_pkg::*;
  logic [31:0] aout_lvl;
  // Converter level: microamps from 4 mA in current mode, microvolts in voltage mode.
  assign aout_lvl = aout_current ? 32'd4000 + 32'(64'(aout_code) * 64'd16000 / 64'd65535)
                                 : 32'(64'(aout_code) * 64'd10000000 / 64'd65535);
  initial begin
    keys = '0;
    meas = '0;
  end
  // Keys are levels; a released key reads as not pressed.
  task automatic hold(input arc_keys_t k, input int n);
    keys <= k;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic put(input logic [15:0] t, input logic ok, input logic oh, input logic ol,
                     input logic [15:0] sv);
    meas <= '{t, ok, oh, ol, sv};
  endtask
endmodule // arc_panel_model
`default_nettype wire

/* File: verif/arc_top_tb.sv */
// Self-checking bench for the alarm, relay and analog output block.
`timescale 1ns/1ns
`default_nettype none
`include "arc_regs.svh"
module arc_top_tb;
  import arc_pkg::*;
  localparam arc_keys_t K_SEL = 4'h1;
  localparam arc_keys_t K_ENT = 4'h2;
  localparam arc_keys_t K_DN = 4'h4;
  localparam arc_keys_t K_UP = 4'h8;
  localparam arc_keys_t K_ARR = 4'hC;
  logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, relay1, relay2, aout_current;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] aout_code;
  logic [3:0] brightness;
  arc_keys_t keys;
  arc_meas_t meas;
  arc_disp_t disp;
  int n_mismatch, tests_run, cyc, tv;
  int fs[6] = '{200, 1000, 2000, 3250, 4750, 10000};
  int at[7] = '{1000, 1001, 991, 990, 199, 209, 210};
  logic [1:0] ae[7] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0};
  arc_menu_t aw[6] = '{ARC_A_EN, ARC_A_HI, ARC_A_LO, ARC_A_DB, ARC_A_LT, ARC_NORM};
  arc_top #(.HOLD_CYC(32'd50), .DATE_CYC(32'd20)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .keys(keys), .meas(meas), .relay1(relay1), .relay2(relay2),
    .aout_code(aout_code), .aout_current(aout_current), .brightness(brightness), .disp(disp));
  arc_panel_model pm (.ref_clk(ref_clk), .relay1(relay1), .relay2(relay2),
    .aout_code(aout_code), .aout_current(aout_current), .keys(keys), .meas(meas));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic waitrdy();
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  // One single word transfer; read data is taken at the data phase edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy();
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic settle();
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic press(input arc_keys_t k);
    pm.hold(k, 2);
    pm.hold(4'h0, 3);
  endtask
  task automatic alm(input logic [1:0] e);
    chk({30'h0, disp.alarm_hi, disp.alarm_lo}, {30'h0, e});
  endtask
  function automatic logic [31:0] aexp(input longint t, input longint f);
    longint v;
    v = (t * ((64'd65535 * 64'd65536 + f - 1) / f)) >> 16;
    return (v > 65535) ? 32'hFFFF : 32'(v);
  endfunction
  initial begin
    rst_n = 1'b0;
    {hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'h2;
    {n_mismatch, tests_run} = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    waitrdy();
    rdchk(`ARC_OFF_CTRL, 32'h4028);
    for (int i = 1; i < 4; i++) rdchk(8'(i * 4), 32'h0);
    chk({28'h0, brightness}, 32'h8);
    bus(1'b1, `ARC_OFF_HI, 32'hFFFF);
    rdchk(`ARC_OFF_HI, 32'h270F);
    bus(1'b1, `ARC_OFF_LO, 32'hFFFF);
    rdchk(`ARC_OFF_LO, 32'h270F);
    bus(1'b1, `ARC_OFF_DB, 32'h3E8);
    rdchk(`ARC_OFF_DB, 32'h3E7);
    bus(1'b1, `ARC_OFF_CMD, 32'h1);
    rdchk(`ARC_OFF_HI, 32'h0);
    rdchk(`ARC_OFF_DB, 32'h0);
    rdchk(`ARC_OFF_DATE, 32'h010100);
    rdchk(8'h40, 32'h0);
    bus(1'b1, `ARC_OFF_CTRL, 32'h4038);
    rdchk(`ARC_OFF_CTRL, 32'h4028);
    for (int r = 0; r < 6; r++) begin
      bus(1'b1, `ARC_OFF_CTRL, 32'h4000 | 32'(r << 3));
      for (int j = 0; j < 4; j++) begin
        tv = fs[r] * j / 2;
        pm.put(16'(tv), 1'b1, 1'b0, 1'b0, 16'h0);
        settle();
        chk({16'h0, aout_code}, aexp(tv, fs[r]));
      end
    end
    chk(pm.aout_lvl, 32'd10000000);
    bus(1'b1, `ARC_OFF_CTRL, 32'h402C);
    settle();
    chk1(aout_current, 1'b1);
    chk(pm.aout_lvl, 32'd20000);
    pm.put(16'd0, 1'b1, 1'b0, 1'b0, 16'h0);
    settle();
    chk(pm.aout_lvl, 32'd4000);
    bus(1'b1, `ARC_OFF_CTRL, 32'h4000);
    pm.put(16'd100, 1'b0, 1'b0, 1'b0, 16'd5000);
    settle();
    chk({16'h0, aout_code}, aexp(5000, 10000));
    pm.put(16'd100, 1'b0, 1'b0, 1'b0, 16'd10000);
    settle();
    chk({16'h0, aout_code}, 32'hFFFF);
    pm.put(16'd100, 1'b1, 1'b0, 1'b0, 16'd5000);
    settle();
    chk({16'h0, aout_code}, aexp(100, 200));
    bus(1'b1, `ARC_OFF_HI, 32'd1000);
    bus(1'b1, `ARC_OFF_LO, 32'd200);
    bus(1'b1, `ARC_OFF_DB, 32'd10);
    bus(1'b1, `ARC_OFF_CTRL, 32'h4281);
    for (int i = 0; i < 7; i++) begin
      pm.put(16'(at[i]), 1'b1, 1'b0, 1'b0, 16'h0);
      settle();
      alm(ae[i]);
      chk({30'h0, relay2, relay1}, {30'h0, ae[i]});
    end
    pm.put(16'd500, 1'b1, 1'b1, 1'b0, 16'h0);
    settle();
    alm(2'h2);
    pm.put(16'd500, 1'b1, 1'b0, 1'b1, 16'h0);
    settle();
    alm(2'h1);
    pm.put(16'd1001, 1'b0, 1'b1, 1'b1, 16'h0);
    settle();
    alm(2'h0);
    bus(1'b1, `ARC_OFF_CTRL, 32'h4141);
    pm.put(16'd500, 1'b1, 1'b0, 1'b0, 16'h0);
    settle();
    chk({30'h0, relay2, relay1}, 32'h3);
    bus(1'b1, `ARC_OFF_CTRL, 32'h4001);
    pm.put(16'd1001, 1'b1, 1'b0, 1'b0, 16'h0);
    settle();
    chk({30'h0, relay2, relay1}, 32'h0);
    bus(1'b1, `ARC_OFF_CTRL, 32'h4283);
    settle();
    pm.put(16'd500, 1'b1, 1'b0, 1'b0, 16'h0);
    settle();
    alm(2'h2);
    bus(1'b1, `ARC_OFF_CMD, 32'h2);
    settle();
    alm(2'h0);
    pm.put(16'd1001, 1'b1, 1'b0, 1'b0, 16'h0);
    settle();
    pm.put(16'd500, 1'b1, 1'b0, 1'b0, 16'h0);
    settle();
    alm(2'h2);
    press(K_SEL);
    alm(2'h0);
    chk(32'(disp.menu), 32'(ARC_PICK));
    for (int i = 0; i < 6; i++) begin
      press(K_ENT);
      chk(32'(disp.menu), 32'(aw[i]));
      if (aw[i] == ARC_A_LT) press(K_DN);
    end
    rdchk(`ARC_OFF_CTRL, 32'h4281);
    press(K_SEL);
    press(K_UP);
    press(K_UP);
    chk({30'h0, disp.pick}, 32'h2);
    press(K_ENT);
    chk(32'(disp.menu), 32'(ARC_O_MD));
    press(K_UP);
    press(K_ENT);
    chk(32'(disp.menu), 32'(ARC_O_RG));
    press(K_UP);
    chk({18'h0, disp.edit}, 32'h1);
    press(K_ENT);
    chk(32'(disp.menu), 32'(ARC_NORM));
    rdchk(`ARC_OFF_CTRL, 32'h428D);
    pm.hold(K_SEL, 30);
    chk1(disp.date_show, 1'b1);
    chk({8'h0, disp.date}, 32'h010100);
    pm.hold(4'h0, 4);
    chk1(disp.date_show, 1'b0);
    chk(32'(disp.menu), 32'(ARC_NORM));
    pm.hold(K_ENT, 60);
    chk1(disp.locked_msg, 1'b1);
    pm.hold(4'h0, 4);
    chk1(disp.locked_msg, 1'b0);
    bus(1'b0, `ARC_OFF_STAT, 32'h0);
    chk1(rd[5], 1'b1);
    press(K_SEL);
    chk(32'(disp.menu), 32'(ARC_NORM));
    pm.hold(K_ARR, 60);
    chk1(disp.all_lit, 1'b0);
    pm.hold(K_ENT, 60);
    chk1(disp.unlocked_msg, 1'b1);
    pm.hold(4'h0, 4);
    chk1(disp.unlocked_msg, 1'b0);
    pm.hold(K_ARR, 60);
    chk1(disp.all_lit, 1'b1);
    pm.hold(4'h0, 4);
    chk1(disp.all_lit, 1'b0);
    rdchk(`ARC_OFF_CTRL, 32'h4028);
    rdchk(`ARC_OFF_HI, 32'h0);
    chk({30'h0, relay2, relay1}, 32'h0);
    report_and_stop();
  end
endmodule // arc_top_tb
`default_nettype wire
